// >>> pkg/lid_defines.svh
// Constants for the character display instruction decoder and its host end.
// Overview of operation
// RL1 - Only command and data registers; select picks.
// RL2 - Busy indicator high while a command executes.
// RL3 - Commands arriving while busy are dropped.
// RL4 - Host polls busy or waits before sending.
// RL5 - RAM address steps after data access.
// RL6 - Configuration command loads width, lines, mux, page.
// RL7 - Command read returns busy and address, always.
// RL8 - Data read returns RAM byte, three cycles.
// RL9 - Data write stores RAM byte, three cycles.
// RL10 - Clear display zeroes address, 165 cycles.
// RL11 - Return home zeroes address and shift.
// RL12 - Entry mode loads direction and shift enable.
// RL13 - Display control loads on, cursor, blink.
// RL14 - Cursor move or display shift, RAM untouched.
// RL15 - Glyph and display address set commands.
// RL16 - Icon control loads icon mode and blink.
// RL17 - Stage count load; host never sends 11.
// RL18 - Voltage value stored into first or second.
// RL19 - Control byte: continuation, select, six zeros.
// RL20 - Screen, display, temperature configuration; 01 ignored.
// RL21 - Page bit picks basic or extended set.
// RL22 - Clear fills blanks and forces increment.
`ifndef LID_DEFINES_SVH
`define LID_DEFINES_SVH

`define LID_CYC_STD    8'd3
`define LID_CYC_CLEAR  8'd165
`define LID_BLANK      8'h20
`define LID_RAM_LAST   7'h7f
`define LID_BUSY_BIT   7
`define LID_CB_CONT    7
`define LID_CB_SEL     6
`define LID_OP_CLEAR   8'h01
`define LID_OP_RSVD    8'h01
`define LID_RST_WIDTH  1'b1
`define LID_RST_STAGES 2'b10

`endif

// >>> pkg/lid_pkg.sv
// Types shared by both ends of the instruction decoder link.
package lid_pkg;

  typedef struct packed {
    logic       interface_width;
    logic       two_line;
    logic       single_line_mux;
    logic       ext_page;
    logic       incr;
    logic       shift_en;
    logic       display_on;
    logic       cursor_on;
    logic       cursor_blink;
    logic       icon_only_mode;
    logic       icon_blink;
    logic       mirror;
    logic       col_rev;
    logic       row_rev;
    logic       temp_coeff_hi;
    logic       temp_coeff_lo;
    logic       stage_count_hi;
    logic       stage_count_lo;
    logic [5:0] volt_a;
    logic [5:0] volt_b;
  } lid_cfg_t;

  typedef enum logic [2:0] {
    LID_H_IDLE = 3'b000,
    LID_H_PCTL = 3'b001,
    LID_H_POLL = 3'b010,
    LID_H_PCHK = 3'b011,
    LID_H_XCTL = 3'b100,
    LID_H_XFER = 3'b101,
    LID_H_RCHK = 3'b110
  } lid_host_st_t;

endpackage

// >>> pkg/lid_if.sv
// Link between the host end and the display controller end.
`timescale 1ns/1ps
interface lid_if;
  logic       rd_stb;
  logic       wr_stb;
  logic       ctrl_stb;
  logic       register_select;
  logic       i2c_sel;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport dev (
    input  rd_stb,
    input  wr_stb,
    input  ctrl_stb,
    input  register_select,
    input  i2c_sel,
    input  wdata,
    output rdata
  );

  modport host (
    output rd_stb,
    output wr_stb,
    output ctrl_stb,
    output register_select,
    output i2c_sel,
    output wdata,
    input  rdata
  );
endinterface

// >>> hdl/lid_dev.sv
// Display controller end: command decoder, address counter, RAMs and busy timing.
`timescale 1ns/1ps
`include "lid_defines.svh"
module lid_dev (
  input  wire logic               i_mclk,
  input  wire logic               i_sys_rst,
  lid_if.dev                      bus,
  output lid_pkg::lid_cfg_t       o_cfg,
  output logic [6:0]              o_ram_address_counter,
  output logic [6:0]              o_display_shift,
  output logic                    o_power_down,
  output logic                    o_busy_indicator
);
  import lid_pkg::*;

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [7:0] display_ram [0:127];
  logic [7:0] glyph_ram   [0:127];

  lid_cfg_t   cfg_q;
  lid_cfg_t   cfg_d;
  logic [7:0] busy_cnt_q;
  logic [6:0] ac_q;
  logic [6:0] ac_d;
  logic [6:0] shift_q;
  logic [6:0] shift_d;
  logic       glyph_sel_q;
  logic       glyph_bit6_q;
  logic       fill_q;
  logic [6:0] fill_idx_q;
  logic       sel_latch_q;
  logic [7:0] rdata_q;

  function automatic logic [6:0] step(input logic [6:0] v, input logic up);
    step = up ? 7'(v + 7'd1) : 7'(v - 7'd1);
  endfunction

  // ==========================================================================
  // Request qualification
  // ==========================================================================
  wire       busy      = (busy_cnt_q != 8'h00);
  wire       sel_eff   = bus.i2c_sel ? sel_latch_q : bus.register_select;
  wire [7:0] cmd       = bus.wdata;
  wire       ext       = cfg_q.ext_page;
  wire       take_cmd  = bus.wr_stb && !sel_eff && !busy; // RL1 RL3
  wire       take_wdat = bus.wr_stb && sel_eff && !busy;  // RL1 RL3
  wire       take_rdat = bus.rd_stb && sel_eff && !busy;  // RL3
  wire       take_stat = bus.rd_stb && !sel_eff;          // RL7

  // ==========================================================================
  // Command decode
  // ==========================================================================
  wire is_nop   = (cmd == 8'h00);
  wire is_fset  = (cmd[7:5] == 3'b001) && !cmd[3];                 // RL6
  wire is_clear = !ext && (cmd == `LID_OP_CLEAR);                   // RL21
  wire is_home  = !ext && (cmd[7:1] == 7'h01);
  wire is_entry = !ext && (cmd[7:2] == 6'h01);
  wire is_dctl  = !ext && (cmd[7:3] == 5'h01);
  wire is_shift = !ext && (cmd[7:4] == 4'h1) && (cmd[1:0] == 2'b00);
  wire is_cga   = !ext && (cmd[7:6] == 2'b01);
  wire is_dda   = !ext && cmd[7];
  wire is_scr   = ext && (cmd[7:1] == 7'h01);
  wire is_dcf   = ext && (cmd[7:2] == 6'h01);
  wire is_icon  = ext && (cmd[7:3] == 5'h01) && !cmd[0];
  wire is_tc    = ext && (cmd[7:2] == 6'h04);
  wire is_stg   = ext && (cmd[7:2] == 6'h10);
  wire is_vlcd  = ext && cmd[7];
  wire known    = is_nop | is_fset | is_clear | is_home | is_entry | is_dctl |
                  is_shift | is_cga | is_dda | is_scr | is_dcf | is_icon |
                  is_tc | is_stg | is_vlcd;
  // Reserved code 01 on the extended page decodes as nothing and never goes busy.
  wire exec_cmd = take_cmd && known; // RL20
  wire exec_any = exec_cmd || take_wdat || take_rdat;

  // ==========================================================================
  // Configuration next state
  // ==========================================================================
  always_comb begin
    cfg_d = cfg_q;
    if (exec_cmd) begin
      if (is_fset) begin
        cfg_d.interface_width = cmd[4]; // RL6
        cfg_d.two_line        = cmd[2]; // RL6
        cfg_d.single_line_mux = cmd[1]; // RL6
        cfg_d.ext_page        = cmd[0]; // RL6 RL21
      end
      if (is_clear) begin
        cfg_d.incr = 1'b1; // RL22
      end
      if (is_entry) begin
        cfg_d.incr     = cmd[1]; // RL12
        cfg_d.shift_en = cmd[0]; // RL12
      end
      if (is_dctl) begin
        cfg_d.display_on   = cmd[2]; // RL13
        cfg_d.cursor_on    = cmd[1]; // RL13
        cfg_d.cursor_blink = cmd[0]; // RL13
      end
      if (is_scr) begin
        cfg_d.mirror = cmd[0]; // RL20
      end
      if (is_dcf) begin
        cfg_d.col_rev = cmd[1]; // RL20
        cfg_d.row_rev = cmd[0]; // RL20
      end
      if (is_icon) begin
        cfg_d.icon_only_mode = cmd[2]; // RL16
        cfg_d.icon_blink     = cmd[1]; // RL16
      end
      if (is_tc) begin
        cfg_d.temp_coeff_hi = cmd[1]; // RL20
        cfg_d.temp_coeff_lo = cmd[0]; // RL20
      end
      if (is_stg) begin
        cfg_d.stage_count_hi = cmd[1]; // RL17
        cfg_d.stage_count_lo = cmd[0]; // RL17
      end
      if (is_vlcd && !cmd[6]) begin
        cfg_d.volt_a = cmd[5:0]; // RL18
      end
      if (is_vlcd && cmd[6]) begin
        cfg_d.volt_b = cmd[5:0]; // RL18
      end
    end
  end

  // ==========================================================================
  // Address counter and display shift next state
  // ==========================================================================
  always_comb begin
    ac_d    = ac_q;
    shift_d = shift_q;
    if (exec_cmd && (is_clear || is_home)) begin
      ac_d    = 7'h00; // RL10 RL11
      shift_d = 7'h00; // RL11
    end else if (exec_cmd && is_cga) begin
      ac_d = {glyph_bit6_q, cmd[5:0]}; // RL15
    end else if (exec_cmd && is_dda) begin
      ac_d = cmd[6:0]; // RL15
    end else if (exec_cmd && is_shift) begin
      if (cmd[3]) begin
        shift_d = step(shift_q, cmd[2]); // RL14
      end else begin
        ac_d = step(ac_q, cmd[2]); // RL14
      end
    end else if (take_wdat || take_rdat) begin
      ac_d = step(ac_q, cfg_q.incr); // RL5
      if (cfg_q.shift_en) begin
        shift_d = step(shift_q, cfg_q.incr); // RL12
      end
    end
  end

  // ==========================================================================
  // Control registers
  // ==========================================================================
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg_q                 <= '0;
      cfg_q.interface_width <= `LID_RST_WIDTH;
      cfg_q.incr            <= 1'b1;
      {cfg_q.stage_count_hi, cfg_q.stage_count_lo} <= `LID_RST_STAGES;
      ac_q                  <= 7'h00;
      shift_q               <= 7'h00;
    end else begin
      cfg_q   <= cfg_d;
      ac_q    <= ac_d;
      shift_q <= shift_d;
    end
  end

  // Reset runs a full clear, so the counter and the fill start loaded.
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy_cnt_q <= `LID_CYC_CLEAR;
    end else if (exec_any) begin
      busy_cnt_q <= (exec_cmd && is_clear) ? `LID_CYC_CLEAR : `LID_CYC_STD; // RL2 RL10
    end else if (busy) begin
      busy_cnt_q <= 8'(busy_cnt_q - 8'd1); // RL2
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fill_q     <= 1'b1;
      fill_idx_q <= 7'h00;
    end else if (exec_cmd && is_clear) begin
      fill_q     <= 1'b1; // RL22
      fill_idx_q <= 7'h00;
    end else if (fill_q) begin
      fill_q     <= (fill_idx_q != `LID_RAM_LAST);
      fill_idx_q <= 7'(fill_idx_q + 7'd1);
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      glyph_sel_q  <= 1'b0;
      glyph_bit6_q <= 1'b0;
    end else if (exec_cmd && is_cga) begin
      glyph_sel_q <= 1'b1; // RL15
    end else if (exec_cmd && is_dda) begin
      glyph_sel_q  <= 1'b0;
      glyph_bit6_q <= cmd[6]; // RL15
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sel_latch_q <= 1'b0;
    end else if (bus.ctrl_stb) begin
      sel_latch_q <= bus.wdata[`LID_CB_SEL]; // RL19
    end
  end

  // ==========================================================================
  // Read data
  // ==========================================================================
  wire [7:0] ram_rd = glyph_sel_q ? glyph_ram[ac_q] : display_ram[ac_q];

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_q <= 8'h00;
    end else if (take_stat) begin
      rdata_q <= {busy, ac_q}; // RL7
    end else if (take_rdat) begin
      rdata_q <= ram_rd; // RL8
    end
  end

  // ==========================================================================
  // RAM arrays
  // ==========================================================================
  wire       dram_we   = fill_q || (take_wdat && !glyph_sel_q);
  wire [6:0] dram_addr = fill_q ? fill_idx_q : ac_q;
  wire [7:0] dram_data = fill_q ? `LID_BLANK : cmd;

  always_ff @(posedge i_mclk) begin
    if (dram_we) begin
      display_ram[dram_addr] <= dram_data; // RL9 RL22
    end
  end

  always_ff @(posedge i_mclk) begin
    if (take_wdat && glyph_sel_q) begin
      glyph_ram[ac_q] <= cmd; // RL9
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign bus.rdata             = rdata_q;
  assign o_cfg                 = cfg_q;
  assign o_ram_address_counter = ac_q;
  assign o_display_shift       = shift_q;
  assign o_power_down          = !cfg_q.display_on; // RL13
  assign o_busy_indicator      = busy;
endmodule

// >>> hdl/lid_host.sv
// Host end: polls the busy indicator, then issues one command or data transfer; status reads are sent without a poll.
`timescale 1ns/1ps
`include "lid_defines.svh"
module lid_host (
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  lid_if.host              bus,
  input  wire logic        i_use_i2c,
  input  wire logic        i_req_valid,
  input  wire logic        i_req_register_select,
  input  wire logic        i_req_read,
  input  wire logic [7:0]  i_req_data,
  output logic             o_req_ready,
  output logic             o_rsp_valid,
  output logic [7:0]       o_rsp_data,
  output logic             o_rsp_rejected
);
  import lid_pkg::*;

  lid_host_st_t st_q;
  lid_host_st_t st_d;
  logic         sel_q;
  logic         read_q;
  logic [7:0]   data_q;
  logic         i2c_q;
  logic         ext_q;

  // ==========================================================================
  // Request classification
  // ==========================================================================
  wire is_stat   = !i_req_register_select && i_req_read;
  wire bad_stage = !i_req_register_select && !i_req_read && ext_q &&
                   (i_req_data == 8'h43); // RL17
  wire is_fset   = !sel_q && !read_q && (data_q[7:5] == 3'b001) && !data_q[3];
  wire go_next   = i_use_i2c ? (st_q == LID_H_PCHK ? 1'b1 : 1'b0) : 1'b0;
  wire accept    = (st_q == LID_H_IDLE) && i_req_valid && !bad_stage;

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_comb begin
    st_d = st_q;
    case (st_q)
      LID_H_IDLE: begin
        if (accept) begin
          if (is_stat) begin
            st_d = i_use_i2c ? LID_H_XCTL : LID_H_XFER; // RL7
          end else begin
            st_d = i_use_i2c ? LID_H_PCTL : LID_H_POLL; // RL4
          end
        end
      end
      LID_H_PCTL: st_d = LID_H_POLL;
      LID_H_POLL: st_d = LID_H_PCHK;
      LID_H_PCHK: begin
        if (bus.rdata[`LID_BUSY_BIT]) begin
          st_d = i2c_q ? LID_H_PCTL : LID_H_POLL; // RL4
        end else begin
          st_d = i2c_q ? LID_H_XCTL : LID_H_XFER;
        end
      end
      LID_H_XCTL: st_d = LID_H_XFER;
      LID_H_XFER: st_d = read_q ? LID_H_RCHK : LID_H_IDLE;
      LID_H_RCHK: st_d = LID_H_IDLE;
      default:    st_d = LID_H_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q   <= LID_H_IDLE;
      sel_q  <= 1'b0;
      read_q <= 1'b0;
      data_q <= 8'h00;
      i2c_q  <= 1'b0;
    end else begin
      st_q <= st_d;
      if (accept) begin
        sel_q  <= i_req_register_select;
        read_q <= i_req_read;
        data_q <= i_req_data;
        i2c_q  <= i_use_i2c;
      end
    end
  end

  // The host tracks the page it last selected so it can screen stage values.
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ext_q <= 1'b0;
    end else if ((st_q == LID_H_XFER) && is_fset) begin
      ext_q <= data_q[0];
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rsp_valid    <= 1'b0;
      o_rsp_data     <= 8'h00;
      o_rsp_rejected <= 1'b0;
    end else begin
      o_rsp_valid    <= ((st_q == LID_H_XFER) && !read_q) || (st_q == LID_H_RCHK) ||
                        ((st_q == LID_H_IDLE) && i_req_valid && bad_stage);
      o_rsp_rejected <= (st_q == LID_H_IDLE) && i_req_valid && bad_stage;
      if (st_q == LID_H_RCHK) begin
        o_rsp_data <= bus.rdata;
      end
    end
  end

  // ==========================================================================
  // Link drive
  // ==========================================================================
  wire ctl_st  = (st_q == LID_H_PCTL) || (st_q == LID_H_XCTL);
  wire ctl_sel = (st_q == LID_H_XCTL) ? sel_q : 1'b0;

  assign bus.ctrl_stb        = ctl_st; // RL19
  assign bus.rd_stb          = (st_q == LID_H_POLL) || ((st_q == LID_H_XFER) && read_q);
  assign bus.wr_stb          = (st_q == LID_H_XFER) && !read_q;
  assign bus.register_select = (st_q == LID_H_XFER) ? sel_q : 1'b0; // RL1
  assign bus.i2c_sel         = i2c_q || go_next;
  assign bus.wdata           = ctl_st ? {1'b0, ctl_sel, 6'h00} : data_q; // RL19
  assign o_req_ready         = (st_q == LID_H_IDLE);
endmodule

// >>> sim/lid_properties.sv
// Concurrent checks on the link between the host end and the controller end.
`timescale 1ns/1ps
module lid_properties (
  input wire logic       i_mclk,
  input wire logic       i_sys_rst,
  input wire logic       rd_stb,
  input wire logic       wr_stb,
  input wire logic       ctrl_stb,
  input wire logic       register_select,
  input wire logic       i2c_sel,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       o_busy_indicator,
  input wire logic [6:0] o_ram_address_counter
);
  logic [7:0] run_q;
  logic       first_q;
  wire        busy = o_busy_indicator;
  wire  [6:0] ac   = o_ram_address_counter;
  wire        dwr  = wr_stb && register_select && !i2c_sel;
  wire        srd  = rd_stb && !register_select && !i2c_sel;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  // ==========
  // Busy run length; the run started by reset is left out.
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      run_q   <= 8'h00;
      first_q <= 1'b1;
    end else begin
      run_q   <= busy ? run_q + 8'h01 : 8'h00;
      first_q <= first_q && busy;
    end
  end

  // ==========
  // Assertions.
  strobe_excl_a: assert property (!(rd_stb && wr_stb))
    else $error("read and write strobes together");
  busy_len_a: assert property ($fell(busy) && !first_q |-> (run_q == 8'd3 || run_q == 8'd165))
    else $error("busy run length wrong");
  busy_hold_a: assert property ($rose(busy) |-> busy[*3])
    else $error("busy dropped early");
  wr_idle_a: assert property (wr_stb |-> !busy)
    else $error("write sent while busy");
  data_step_a: assert property (dwr |=> busy && (ac == $past(ac) + 7'h01 || ac == $past(ac) - 7'h01))
    else $error("data write did not step the address");
  drop_busy_a: assert property ((rd_stb || wr_stb) && busy |=> $stable(ac))
    else $error("access during busy changed the address");
  status_rd_a: assert property (srd |=> rdata == {$past(busy), $past(ac)})
    else $error("status read value wrong");
  rdata_hold_a: assert property (!rd_stb |=> $stable(rdata))
    else $error("read data changed without a read");
  ctrl_zero_a: assert property (ctrl_stb |-> wdata[5:0] == 6'h00 && !rd_stb && !wr_stb)
    else $error("control byte malformed");

  cover property (dwr);
  cover property ($fell(busy) && run_q == 8'd165);
  cover property (rd_stb && busy);
  cover property (ctrl_stb);
endmodule

// >>> sim/tb.sv
// Bench joining the host end and the controller end through the link.
`timescale 1ns/1ps
module tb;
  import lid_pkg::*;
  logic           i_mclk;
  logic           i_sys_rst;
  logic           i_use_i2c;
  logic           i_req_valid;
  logic           i_req_register_select;
  logic           i_req_read;
  logic     [7:0] i_req_data;
  logic           o_req_ready;
  logic           o_rsp_valid;
  logic     [7:0] o_rsp_data;
  logic           o_rsp_rejected;
  lid_cfg_t       o_cfg;
  logic     [6:0] o_ram_address_counter;
  logic     [6:0] o_display_shift;
  logic           o_power_down;
  logic           o_busy_indicator;
  lid_cfg_t       exp_cfg;
  logic     [7:0] rsp;
  logic           rej;
  logic           use_i2c;
  int             bad_count = 0;
  int             checked = 0;
  int             cyc = 0;

  lid_if lif ();
  lid_dev lid_dev_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .bus(lif), .o_cfg(o_cfg),
    .o_ram_address_counter(o_ram_address_counter), .o_display_shift(o_display_shift),
    .o_power_down(o_power_down), .o_busy_indicator(o_busy_indicator));
  lid_host lid_host_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .bus(lif), .i_use_i2c(i_use_i2c),
    .i_req_valid(i_req_valid), .i_req_register_select(i_req_register_select),
    .i_req_read(i_req_read), .i_req_data(i_req_data), .o_req_ready(o_req_ready),
    .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data), .o_rsp_rejected(o_rsp_rejected));
  lid_properties lid_properties_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .rd_stb(lif.rd_stb), .wr_stb(lif.wr_stb), .ctrl_stb(lif.ctrl_stb),
    .register_select(lif.register_select), .i2c_sel(lif.i2c_sel), .wdata(lif.wdata),
    .rdata(lif.rdata), .o_busy_indicator(o_busy_indicator),
    .o_ram_address_counter(o_ram_address_counter));

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  // ==========
  // Shared tasks.
  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic xfer(input logic rs, input logic rd, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_req_valid <= 1'b1;
    i_req_register_select <= rs;
    i_req_read <= rd;
    i_req_data <= d;
    i_use_i2c <= use_i2c;
    do begin
      @(posedge i_mclk);
      i_req_valid <= 1'b0;
      #1;
      n++;
    end while (o_rsp_valid !== 1'b1 && n < 400);
    rsp = o_rsp_data;
    rej = o_rsp_rejected;
    chk("rsp_valid", 32'h1, {31'h0, o_rsp_valid});
    chk("req_ready", 32'h1, {31'h0, o_req_ready});
  endtask

  task automatic cfgc(input logic [7:0] d);
    xfer(1'b0, 1'b0, d);
    chk("cfg", {2'b00, exp_cfg}, {2'b00, o_cfg});
  endtask

  task automatic ac_is(input logic [6:0] e);
    chk("ac", {25'h0, e}, {25'h0, o_ram_address_counter});
  endtask

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      $display("[FAIL] run_cycles expected below 6000 seen %0d", cyc);
      finish_test();
    end
  end

  // ==========
  // Main sequence.
  initial begin
    i_sys_rst = 1'b1;
    i_use_i2c = 1'b0;
    i_req_valid = 1'b0;
    i_req_register_select = 1'b0;
    i_req_read = 1'b0;
    i_req_data = 8'h00;
    use_i2c = 1'b0;
    exp_cfg = '0;
    exp_cfg.interface_width = 1'b1;
    exp_cfg.incr = 1'b1;
    exp_cfg.stage_count_hi = 1'b1;
    repeat (8) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(posedge i_mclk);
    #1;
    chk("busy", 32'h1, {31'h0, o_busy_indicator});
    chk("cfg", {2'b00, exp_cfg}, {2'b00, o_cfg});
    $display("reset test done");
    {exp_cfg.display_on, exp_cfg.cursor_on, exp_cfg.cursor_blink} = 3'b111;
    cfgc(8'h0f);
    chk("pdown", 32'h0, {31'h0, o_power_down});
    {exp_cfg.display_on, exp_cfg.cursor_on, exp_cfg.cursor_blink} = 3'b010;
    cfgc(8'h0a);
    chk("pdown", 32'h1, {31'h0, o_power_down});
    {exp_cfg.interface_width, exp_cfg.two_line, exp_cfg.single_line_mux} = 3'b111;
    exp_cfg.ext_page = 1'b1;
    cfgc(8'h37);
    {exp_cfg.icon_only_mode, exp_cfg.icon_blink} = 2'b11;
    cfgc(8'h0e);
    exp_cfg.mirror = 1'b1;
    cfgc(8'h03);
    {exp_cfg.col_rev, exp_cfg.row_rev} = 2'b11;
    cfgc(8'h07);
    {exp_cfg.temp_coeff_hi, exp_cfg.temp_coeff_lo} = 2'b10;
    cfgc(8'h12);
    {exp_cfg.stage_count_hi, exp_cfg.stage_count_lo} = 2'b01;
    cfgc(8'h41);
    chk("rejected", 32'h0, {31'h0, rej});
    exp_cfg.volt_a = 6'h2a;
    cfgc(8'haa);
    exp_cfg.volt_b = 6'h15;
    cfgc(8'hd5);
    cfgc(8'h01);
    cfgc(8'h43);
    chk("rejected", 32'h1, {31'h0, rej});
    {exp_cfg.interface_width, exp_cfg.two_line, exp_cfg.single_line_mux} = 3'b100;
    exp_cfg.ext_page = 1'b0;
    cfgc(8'h30);
    $display("configuration test done");
    {exp_cfg.incr, exp_cfg.shift_en} = 2'b10;
    cfgc(8'h06);
    xfer(1'b0, 1'b0, 8'h85);
    ac_is(7'h05);
    xfer(1'b1, 1'b0, 8'h41);
    ac_is(7'h06);
    exp_cfg.incr = 1'b0;
    cfgc(8'h04);
    xfer(1'b1, 1'b0, 8'h42);
    ac_is(7'h05);
    xfer(1'b1, 1'b1, 8'h00);
    chk("rdata", {24'h0, 8'h41}, {24'h0, rsp});
    ac_is(7'h04);
    xfer(1'b0, 1'b1, 8'h00);
    chk("status_ac", {25'h0, 7'h04}, {25'h0, rsp[6:0]});
    chk("status_busy", 32'h0, {31'h0, rsp[7]});
    xfer(1'b0, 1'b0, 8'h14);
    ac_is(7'h05);
    xfer(1'b0, 1'b0, 8'h1c);
    chk("shift_moved", 32'h1, {25'h0, o_display_shift});
    xfer(1'b0, 1'b0, 8'h02);
    ac_is(7'h00);
    chk("shift", 32'h0, {25'h0, o_display_shift});
    xfer(1'b0, 1'b0, 8'hc5);
    xfer(1'b1, 1'b1, 8'h00);
    chk("rdata", {24'h0, 8'h20}, {24'h0, rsp});
    xfer(1'b0, 1'b0, 8'h45);
    ac_is(7'h45);
    $display("address and data test done");
    {exp_cfg.incr, exp_cfg.shift_en} = 2'b01;
    cfgc(8'h05);
    xfer(1'b0, 1'b0, 8'h90);
    xfer(1'b1, 1'b0, 8'h55);
    chk("shift", {25'h0, 7'h7f}, {25'h0, o_display_shift});
    exp_cfg.incr = 1'b1;
    cfgc(8'h01);
    ac_is(7'h00);
    xfer(1'b0, 1'b1, 8'h00);
    chk("status_busy", 32'h1, {31'h0, rsp[7]});
    xfer(1'b0, 1'b0, 8'h90);
    xfer(1'b1, 1'b1, 8'h00);
    chk("rdata", {24'h0, 8'h20}, {24'h0, rsp});
    $display("clear test done");
    use_i2c = 1'b1;
    xfer(1'b0, 1'b0, 8'h86);
    ac_is(7'h06);
    xfer(1'b1, 1'b0, 8'h33);
    ac_is(7'h07);
    xfer(1'b0, 1'b0, 8'h86);
    xfer(1'b1, 1'b1, 8'h00);
    chk("rdata", {24'h0, 8'h33}, {24'h0, rsp});
    use_i2c = 1'b0;
    $display("serial control test done");
    finish_test();
  end
endmodule
